// *** rtl/vpg_pkg.sv ***
/*
 * Constants, carrier types and decode functions of the video test pattern generator.
 * Assumes one clock domain and 10-bit luma and chroma words per sample.
 */
package vpg_pkg;

    // Register byte offsets and values after reset.
    localparam logic [11:0] VPG_CTRL_OFS = 12'h000;
    localparam logic [11:0] VPG_STAT_OFS = 12'h004;
    localparam logic [11:0] VPG_FRAME_OFS = 12'h008;
    localparam logic [13:0] VPG_CTRL_RST = 14'h0000;
    localparam logic [1:0] VPG_REG_CTRL = 2'h0;
    localparam logic [1:0] VPG_REG_STAT = 2'h1;
    localparam logic [1:0] VPG_REG_FRAME = 2'h2;
    localparam logic [1:0] VPG_REG_NONE = 2'h3;

    // Transmit standard codes.
    localparam logic [2:0] VPG_STD_SD = 3'h0;
    localparam logic [2:0] VPG_STD_HD = 3'h1;
    localparam logic [2:0] VPG_STD_3GB = 3'h2;
    localparam logic [2:0] VPG_STD_3GA = 3'h3;

    // Format codes; the codes not listed are reserved.
    localparam logic [3:0] VPG_F_525I = 4'h0;
    localparam logic [3:0] VPG_F_625I = 4'h1;
    localparam logic [3:0] VPG_F_1080I60 = 4'h4;
    localparam logic [3:0] VPG_F_1080I50 = 4'h5;
    localparam logic [3:0] VPG_F_1080P24 = 4'h6;
    localparam logic [3:0] VPG_F_720P60 = 4'h7;
    localparam logic [3:0] VPG_F_720P50 = 4'h8;
    localparam logic [3:0] VPG_F_720P30 = 4'h9;
    localparam logic [3:0] VPG_F_720P25 = 4'ha;
    localparam logic [3:0] VPG_F_720P24 = 4'hb;
    localparam logic [3:0] VPG_F_1080P30 = 4'hc;
    localparam logic [3:0] VPG_F_1080P25 = 4'hd;
    localparam logic [3:0] VPG_F_1080SF24 = 4'he;

    // Video levels and timing reference words.
    localparam logic [9:0] VPG_TRS_ONES = 10'h3ff;
    localparam logic [9:0] VPG_TRS_ZERO = 10'h000;
    localparam logic [9:0] VPG_Y_BLACK = 10'h040;
    localparam logic [9:0] VPG_C_ZERO = 10'h200;
    localparam logic [9:0] VPG_Y_WHITE = 10'h3ac;
    localparam logic [9:0] VPG_PATH_Y1 = 10'h198;
    localparam logic [9:0] VPG_PATH_C1 = 10'h300;
    localparam logic [9:0] VPG_PATH_Y2 = 10'h110;
    localparam logic [12:0] VPG_TRS_LEN = 13'h0004;

    typedef struct packed {
        logic sgmt;
        logic no_color;
        logic black;
        logic patho;
        logic bar_amplitude_select;
        logic frac;
        logic dual_link_map_enable;
        logic [3:0] fmt;
        logic [2:0] std;
    } vpg_ctrl_t;

    typedef struct packed {
        logic [12:0] h_total;
        logic [12:0] h_active;
        logic [7:0] seg;
        logic [10:0] v_total;
        logic [10:0] a1s;
        logic [10:0] a1e;
        logic [10:0] f2s;
        logic [10:0] a2s;
        logic [10:0] a2e;
        logic il;
    } vpg_tim_t;

    typedef struct packed {
        logic [9:0] y;
        logic [9:0] c;
        logic trs;
        logic [10:0] line;
        logic field;
    } vpg_vid_t;

    // Line and field timing per format; reserved codes fall back to 525i.
    function automatic vpg_tim_t vpg_timing(input logic [3:0] fmt);
        vpg_tim_t t;
        t = '{13'd858, 13'd720, 8'd90, 11'd525, 11'd20, 11'd263, 11'd266, 11'd283, 11'd525, 1'b1};
        case (fmt)
            VPG_F_625I: t = '{13'd864, 13'd720, 8'd90, 11'd625, 11'd23, 11'd310, 11'd313, 11'd336, 11'd623, 1'b1};
            VPG_F_1080I60: t = '{13'd2200, 13'd1920, 8'd240, 11'd1125, 11'd21, 11'd560, 11'd563, 11'd584, 11'd1123, 1'b1};
            VPG_F_1080I50: t = '{13'd2640, 13'd1920, 8'd240, 11'd1125, 11'd21, 11'd560, 11'd563, 11'd584, 11'd1123, 1'b1};
            VPG_F_1080SF24: t = '{13'd2750, 13'd1920, 8'd240, 11'd1125, 11'd21, 11'd560, 11'd563, 11'd584, 11'd1123, 1'b1};
            VPG_F_1080P24: t = '{13'd2750, 13'd1920, 8'd240, 11'd1125, 11'd42, 11'd1121, 11'd0, 11'd0, 11'd0, 1'b0};
            VPG_F_1080P30: t = '{13'd2200, 13'd1920, 8'd240, 11'd1125, 11'd42, 11'd1121, 11'd0, 11'd0, 11'd0, 1'b0};
            VPG_F_1080P25: t = '{13'd2640, 13'd1920, 8'd240, 11'd1125, 11'd42, 11'd1121, 11'd0, 11'd0, 11'd0, 1'b0};
            VPG_F_720P60: t = '{13'd1650, 13'd1280, 8'd160, 11'd750, 11'd26, 11'd745, 11'd0, 11'd0, 11'd0, 1'b0};
            VPG_F_720P50: t = '{13'd1980, 13'd1280, 8'd160, 11'd750, 11'd26, 11'd745, 11'd0, 11'd0, 11'd0, 1'b0};
            VPG_F_720P30: t = '{13'd3300, 13'd1280, 8'd160, 11'd750, 11'd26, 11'd745, 11'd0, 11'd0, 11'd0, 1'b0};
            VPG_F_720P25: t = '{13'd3960, 13'd1280, 8'd160, 11'd750, 11'd26, 11'd745, 11'd0, 11'd0, 11'd0, 1'b0};
            VPG_F_720P24: t = '{13'd4125, 13'd1280, 8'd160, 11'd750, 11'd26, 11'd745, 11'd0, 11'd0, 11'd0, 1'b0};
            default: t = t;
        endcase
        return t;
    endfunction

    // Bar colours as {y, cb, cr}, white first and black last.
    function automatic logic [29:0] vpg_bar(input logic [2:0] idx, input logic full);
        logic [29:0] b;
        b = {VPG_Y_BLACK, VPG_C_ZERO, VPG_C_ZERO};
        case ({full, idx})
            4'h0: b = {10'd721, 10'd512, 10'd512};
            4'h1: b = {10'd674, 10'd176, 10'd543};
            4'h2: b = {10'd581, 10'd589, 10'd176};
            4'h3: b = {10'd534, 10'd253, 10'd207};
            4'h4: b = {10'd251, 10'd771, 10'd817};
            4'h5: b = {10'd204, 10'd435, 10'd848};
            4'h6: b = {10'd111, 10'd848, 10'd481};
            4'h8: b = {10'd940, 10'd512, 10'd512};
            4'h9: b = {10'd877, 10'd64, 10'd553};
            4'ha: b = {10'd754, 10'd615, 10'd64};
            4'hb: b = {10'd691, 10'd167, 10'd105};
            4'hc: b = {10'd313, 10'd857, 10'd919};
            4'hd: b = {10'd250, 10'd409, 10'd960};
            4'he: b = {10'd127, 10'd960, 10'd471};
            default: b = b;
        endcase
        return b;
    endfunction

endpackage

// *** rtl/vpg_top.sv ***
/*
 * Video test pattern generator with an APB register slave.
 * Assumes pclk is also the sample clock of the SDI transmitter that takes vid,
 * and that the transmitter applies the fractional clock when frac_rate_enable is high.
 */
// Implementation choices: the address map and register access over APB.
// What this block does
// - Transmit standard code 000 SD, 001 HD or dual link, 010 3G-B, 011 3G-A.
// - Format 0000 525i, 0001 625i, 0100 1080i60/sF30, 0101 1080i50/sF25.
// - Format 0110 1080p24, 1100 1080p30/60, 1101 1080p25/50, 1110 1080sF24.
// - Rate select 0 gives integer rate, 1 gives the 1/1.001 rate.
// - Rate select is ignored for 525i, 625i, 1080i50, 720p50, 720p25, 1080p25.
// - Bar amplitude select 0 gives 75% bars, 1 gives 100% bars.
// - Pathological select replaces the bars with the pathological pattern.
// - Black select outputs a black picture.
// - Colourless select outputs the bars without colour.
// - Segmented select gives a segmented frame picture, only for formats 0100 and 0101.
`timescale 1ns/10ps

module vpg_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output vpg_pkg::vpg_vid_t vid,
    output logic [2:0] tx_std,
    output logic dual_link_map_enable,
    output logic frac_rate_enable
);

    // Maps a bus address onto a register slot; used by the read and write paths.
    function automatic logic [1:0] reg_sel(input logic [11:0] a);
        logic [1:0] r;
        r = vpg_pkg::VPG_REG_NONE;
        if (a == vpg_pkg::VPG_CTRL_OFS) begin
            r = vpg_pkg::VPG_REG_CTRL;
        end else if (a == vpg_pkg::VPG_STAT_OFS) begin
            r = vpg_pkg::VPG_REG_STAT;
        end else if (a == vpg_pkg::VPG_FRAME_OFS) begin
            r = vpg_pkg::VPG_REG_FRAME;
        end
        return r;
    endfunction

    // Software copy of the selects, and the copy that drives the picture.
    vpg_pkg::vpg_ctrl_t ctrl_q;
    vpg_pkg::vpg_ctrl_t act_q;
    vpg_pkg::vpg_tim_t tim;
    vpg_pkg::vpg_vid_t vid_d;
    // Bus answer registers and the frame counter.
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] frame_q;
    // Raster position, bar position and moving stripe.
    logic [12:0] h_q;
    logic [10:0] v_q;
    logic [7:0] seg_q;
    logic [2:0] bar_q;
    logic csel_q;
    logic [5:0] mot_q;
    // Registered copies of the selects that the transmitter follows.
    logic [2:0] tx_std_q;
    logic dl_q;
    logic frac_q;
    // Combinational helpers of the bus path and the raster decode.
    logic [31:0] rd_d;
    logic [1:0] sel;
    logic wr_take;
    logic hend;
    logic fend;
    logic f2_start;
    logic field;
    logic vblank;
    logic hact;
    logic [12:0] hstart;
    logic [12:0] sav_h;
    logic eav;
    logic sav;
    logic [1:0] trs_idx;
    logic [9:0] xyz;
    logic [10:0] act_line;
    logic [10:0] half;
    logic sgmt_eff;
    logic frac_ok;
    logic [29:0] bar;

    // Address decode, and the edge at which a write lands.
    assign sel = reg_sel(paddr);
    assign wr_take = psel && penable && pready_q && pwrite;

    // Read data for the slot being addressed; the frame counter reads live.
    always_comb begin
        rd_d = 32'h0000_0000;
        case (sel)
            vpg_pkg::VPG_REG_CTRL: rd_d = {18'h00000, ctrl_q};
            vpg_pkg::VPG_REG_STAT: rd_d = {19'h00000, vblank, field, v_q};
            vpg_pkg::VPG_REG_FRAME: rd_d = frame_q;
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // The slave answers in the first access cycle; read data is caught in the setup cycle.
    // A write answers with zero read data, so the bus never shows stale contents.
    // Unmapped addresses and writes to read-only slots answer with an error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= psel && !penable;
            if (psel && !penable) begin
                prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
                pslverr_q <= (sel == vpg_pkg::VPG_REG_NONE) ||
                             (pwrite && sel != vpg_pkg::VPG_REG_CTRL);
            end else begin
                prdata_q <= 32'h0000_0000;
                pslverr_q <= 1'b0;
            end
        end
    end

    // Control register, written byte by byte; only the low two lanes hold bits.
    // A write with no strobe lane set changes nothing but still answers without error.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= vpg_pkg::VPG_CTRL_RST;
        end else if (wr_take && sel == vpg_pkg::VPG_REG_CTRL) begin
            if (pstrb[0]) begin
                ctrl_q[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                ctrl_q[13:8] <= pwdata[13:8];
            end
        end
    end

    // Settings take effect only at a frame boundary, so a picture is never mixed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_q <= vpg_pkg::VPG_CTRL_RST;
        end else if (fend) begin
            act_q <= ctrl_q;
        end
    end

    // Timing of the active format; a reserved code is timed as 525i, so the raster never stalls.
    // The line counter runs up to v_total inclusive because lines count from one.
    assign tim = vpg_pkg::vpg_timing(act_q.fmt);
    assign hend = h_q == tim.h_total - 13'd1;
    assign fend = hend && v_q == tim.v_total;
    assign f2_start = hend && tim.il && v_q == tim.f2s - 11'd1;
    assign hstart = tim.h_total - tim.h_active;
    assign sav_h = hstart - vpg_pkg::VPG_TRS_LEN;
    assign hact = h_q >= hstart;

    // Horizontal sample and line counters; lines are numbered from one.
    // The frame counter wraps silently once it has counted all 32 bits.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            h_q <= 13'h0000;
            v_q <= 11'h001;
            frame_q <= 32'h0000_0000;
        end else if (hend) begin
            h_q <= 13'h0000;
            v_q <= fend ? 11'h001 : v_q + 11'h001;
            frame_q <= fend ? frame_q + 32'h0000_0001 : frame_q;
        end else begin
            h_q <= h_q + 13'h0001;
        end
    end

    // Field and vertical blanking flags follow the line count of the active format.
    // The half point splits the pathological pattern into its two stress regions.
    assign field = tim.il && v_q >= tim.f2s;
    assign vblank = !((v_q >= tim.a1s && v_q <= tim.a1e) || (tim.il && v_q >= tim.a2s && v_q <= tim.a2e));
    assign act_line = field ? v_q - tim.a2s : v_q - tim.a1s;
    assign half = field ? (tim.a2e - tim.a2s + 11'd1) >> 1 : (tim.a1e - tim.a1s + 11'd1) >> 1;

    // End and start of active video codes: ones, zero, zero, then the flag word.
    // The start code sits in the last four samples before active video.
    assign eav = h_q < vpg_pkg::VPG_TRS_LEN;
    assign sav = h_q >= sav_h && !hact;
    assign trs_idx = eav ? h_q[1:0] : 2'(h_q - sav_h);
    assign xyz = {1'b1, field, vblank, eav, vblank ^ eav, field ^ eav, field ^ vblank,
                  field ^ vblank ^ eav, 2'b00};

    // Bar position: a segment counter steps the bar index across the active line.
    // Chroma alternates Cb then Cr, starting with Cb on the first active sample.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seg_q <= 8'h00;
            bar_q <= 3'h0;
            csel_q <= 1'b0;
        end else if (!hact) begin
            seg_q <= 8'h00;
            bar_q <= 3'h0;
            csel_q <= 1'b0;
        end else begin
            csel_q <= !csel_q;
            if (seg_q == tim.seg - 8'h01) begin
                seg_q <= 8'h00;
                bar_q <= bar_q + 3'h1;
            end else begin
                seg_q <= seg_q + 8'h01;
            end
        end
    end

    // A segmented picture is one frame split over two fields, so the moving
    // stripe advances once per frame; interlaced video advances it every field.
    assign sgmt_eff = act_q.sgmt && (act_q.fmt == vpg_pkg::VPG_F_1080I60 ||
                                     act_q.fmt == vpg_pkg::VPG_F_1080I50);

    // Stripe position has six bits, so it wraps every 64 steps; the stripe repeats every 64 active lines down the picture.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mot_q <= 6'h00;
        end else if (fend || (f2_start && !sgmt_eff)) begin
            mot_q <= mot_q + 6'h01;
        end
    end

    assign bar = vpg_pkg::vpg_bar(bar_q, act_q.bar_amplitude_select);

    // Sample selection: timing codes, then blanking, then the chosen picture.
    // Blanking wins over every picture select, so the references always frame clean lines.
    always_comb begin
        vid_d = '0;
        vid_d.line = v_q;
        vid_d.field = field;
        vid_d.y = vpg_pkg::VPG_Y_BLACK;
        vid_d.c = vpg_pkg::VPG_C_ZERO;
        if (eav || sav) begin
            vid_d.trs = trs_idx == 2'h0;
            case (trs_idx)
                2'h0: vid_d.y = vpg_pkg::VPG_TRS_ONES;
                2'h3: vid_d.y = xyz;
                default: vid_d.y = vpg_pkg::VPG_TRS_ZERO;
            endcase
            vid_d.c = vid_d.y;
        end else if (!hact || vblank) begin
            vid_d.y = vpg_pkg::VPG_Y_BLACK;
        end else if (act_q.black) begin
            vid_d.y = vpg_pkg::VPG_Y_BLACK;
        end else if (act_q.patho) begin
            // Top half stresses the equaliser, bottom half the PLL.
            vid_d.y = act_line < half ? vpg_pkg::VPG_PATH_Y1 : vpg_pkg::VPG_PATH_Y2;
            vid_d.c = act_line < half ? vpg_pkg::VPG_PATH_C1 : vpg_pkg::VPG_C_ZERO;
        end else if (act_line[5:0] == mot_q) begin
            vid_d.y = vpg_pkg::VPG_Y_WHITE;
        end else begin
            vid_d.y = bar[29:20];
            vid_d.c = act_q.no_color ? vpg_pkg::VPG_C_ZERO : (csel_q ? bar[9:0] : bar[19:10]);
        end
    end

    // Formats with no fractional variant run at the integer rate whatever is asked.
    // This keeps the transmitter from switching rate on a format that has only one rate.
    // Reserved codes are left to the default branch, as software never applies them.
    always_comb begin
        case (act_q.fmt)
            vpg_pkg::VPG_F_525I, vpg_pkg::VPG_F_625I, vpg_pkg::VPG_F_1080I50,
            vpg_pkg::VPG_F_720P50, vpg_pkg::VPG_F_720P25, vpg_pkg::VPG_F_1080P25: frac_ok = 1'b0;
            default: frac_ok = 1'b1;
        endcase
    end

    // Output stage; everything the transmitter sees comes from a flip-flop.
    // The standard and rate copies lag the active set by one clock, in step with the first EAV.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vid <= '{vpg_pkg::VPG_Y_BLACK, vpg_pkg::VPG_C_ZERO, 1'b0, 11'h000, 1'b0};
            tx_std_q <= vpg_pkg::VPG_STD_SD;
            dl_q <= 1'b0;
            frac_q <= 1'b0;
        end else begin
            vid <= vid_d;
            tx_std_q <= act_q.std;
            dl_q <= act_q.dual_link_map_enable;
            frac_q <= act_q.frac && frac_ok;
        end
    end

    // Ports are driven straight from the registers above.
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign tx_std = tx_std_q;
    assign dual_link_map_enable = dl_q;
    assign frac_rate_enable = frac_q;

endmodule

// *** tb/vpg_checker.sv ***
/*
 * Port checker of the video test pattern generator: bus answer timing and
 * timing reference words. Assumes one clock domain and the bind at its foot.
 */
`timescale 1ns/10ps
module vpg_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire vpg_pkg::vpg_vid_t vid,
    input wire logic [2:0] tx_std,
    input wire logic dual_link_map_enable,
    input wire logic frac_rate_enable
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Register answers come one cycle after setup and stand one cycle.
    a_ready_after_setup:
    assert property (psel && !penable |=> pready)
    else $error("pready late");
    a_ready_one_pulse:
    assert property (pready |=> !pready)
    else $error("pready too long");
    a_rdata_idle_zero:
    assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not idle");
    a_err_with_ready:
    assert property (pslverr |-> pready && psel && penable)
    else $error("stray pslverr");
    // Each timing reference opens with 3ff, 000, 000 and a protected word.
    a_trs_zero_words:
    assert property (vid.trs |=> (vid.y == 10'h000 && !vid.trs) [*2])
    else $error("trs words wrong");
    a_xyz_protect:
    assert property (vid.trs |-> ##3 (vid.y[9] && vid.y[1:0] == 2'h0 && vid.y[5] == (vid.y[7] ^ vid.y[6])
        && vid.y[4] == (vid.y[8] ^ vid.y[6]) && vid.y[3] == (vid.y[8] ^ vid.y[7])
        && vid.y[2] == (vid.y[8] ^ vid.y[7] ^ vid.y[6])))
    else $error("xyz bad");
    a_eav_blanking:
    assert property (vid.trs ##3 vid.y[6] |=> vid.y == 10'h040 && vid.c == 10'h200)
    else $error("no blanking");
    // Standard and rate outputs may only move at a frame start.
    a_std_frame_edge:
    assert property ($changed({tx_std, dual_link_map_enable, frac_rate_enable})
        |-> ##[0:1] (vid.trs && vid.line == 11'd1))
    else $error("std moved mid frame");
    c_sav_seen: cover property (vid.trs ##3 !vid.y[6]);
    c_bus_error: cover property (pslverr);
    c_read_data: cover property (pready && prdata != 32'h0);
endmodule

bind vpg_top vpg_checker vpg_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .vid(vid), .tx_std(tx_std),
    .dual_link_map_enable(dual_link_map_enable), .frac_rate_enable(frac_rate_enable));

// *** tb/vpg_sink.sv ***
/*
 * Model of the transmitter that takes the generated stream: it follows the
 * line numbers of the timing references. Assumes vid changes on rising edges.
 */
`timescale 1ns/10ps
module vpg_sink (
    input wire logic pclk,
    input wire logic presetn,
    input wire vpg_pkg::vpg_vid_t vid,
    output logic [31:0] bad_q,
    output logic [31:0] trs_q
);
    logic [10:0] line_q;

    // A reference word may only repeat the line, step it by one or wrap to 1.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bad_q <= 32'h0;
            trs_q <= 32'h0;
            line_q <= 11'h000;
        end else if (vid.trs) begin
            trs_q <= trs_q + 32'h1;
            line_q <= vid.line;
            if (vid.line != line_q && vid.line != line_q + 11'h001 && vid.line != 11'h001) begin
                bad_q <= bad_q + 32'h1;
            end
        end
    end
endmodule

// *** tb/vpg_top_bench.sv ***
/*
 * Self-checking bench of the pattern generator: register path and first frame.
 * Assumes the checker is bound and the sink model sits on the video output.
 */
`timescale 1ns/10ps
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin error_cnt++; $display("mismatch at %0t: %s", $time, m); end end
module vpg_top_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata, rd, sink_bad, sink_trs;
    logic pready, pslverr, er, dl, frac;
    logic [2:0] tx_std;
    vpg_pkg::vpg_vid_t vid;
    int error_cnt = 0;
    int check_count = 0;
    logic [3:0] fmts[13] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he};
    logic [9:0] y75[8] = '{10'd721, 10'd674, 10'd581, 10'd534, 10'd251, 10'd204, 10'd111, 10'd64};
    logic [9:0] cb75[8] = '{10'd512, 10'd176, 10'd589, 10'd253, 10'd771, 10'd435, 10'd848, 10'd512};
    logic [9:0] cr75[8] = '{10'd512, 10'd543, 10'd176, 10'd207, 10'd817, 10'd848, 10'd481, 10'd512};

    vpg_top vpg_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .vid(vid), .tx_std(tx_std), .dual_link_map_enable(dl), .frac_rate_enable(frac));
    vpg_sink vpg_sink_inst (.pclk(pclk), .presetn(presetn), .vid(vid), .bad_q(sink_bad), .trs_q(sink_trs));

    // Bus signals move by non-blocking assignment just after a rising edge. pready is judged at the
    // rising edge itself, before the design updates, which is where the write lands and read data is taken.
    // Video outputs are read on the falling edge so they never race the design's updates.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic t_walk();
        @(posedge pclk);
        @(negedge pclk);
        `CHK({vid.trs, vid.line, vid.y}, {1'b1, 11'd1, 10'h3ff}, "eav start")
        repeat (3) @(negedge pclk);
        `CHK(vid.y, 10'h2d8, "eav xyz")
        @(negedge pclk);
        `CHK({vid.y, vid.c}, {vpg_pkg::VPG_Y_BLACK, vpg_pkg::VPG_C_ZERO}, "blanking")
        repeat (130) @(negedge pclk);
        `CHK({vid.trs, vid.y}, {1'b1, 10'h3ff}, "sav start")
        repeat (3) @(negedge pclk);
        `CHK(vid.y, 10'h2ac, "sav xyz")
        @(negedge pclk);
        `CHK({vid.y, vid.c}, {vpg_pkg::VPG_Y_BLACK, vpg_pkg::VPG_C_ZERO}, "line 1 active blanked")
    endtask

    task automatic t_regs();
        logic [31:0] d;
        logic [2:0] s;
        apb(1'b0, vpg_pkg::VPG_CTRL_OFS, 32'h0, 4'hf);
        `CHK(rd, 32'h0, "ctrl reset")
        for (int i = 0; i < 13; i++) begin
            s = 3'(i % 4);
            d = {18'h0, 6'(i), s == 3'h1 || s == 3'h2, fmts[i], s};
            apb(1'b1, vpg_pkg::VPG_CTRL_OFS, d, 4'hf);
            apb(1'b0, vpg_pkg::VPG_CTRL_OFS, 32'h0, 4'hf);
            `CHK(rd, d, "ctrl readback")
        end
        apb(1'b1, vpg_pkg::VPG_CTRL_OFS, 32'h00003f55, 4'h1);
        apb(1'b0, vpg_pkg::VPG_CTRL_OFS, 32'h0, 4'hf);
        `CHK(rd, {d[31:8], 8'h55}, "byte lane write")
        `CHK({tx_std, frac, dl}, 5'h00, "selects applied mid frame")
        apb(1'b1, vpg_pkg::VPG_CTRL_OFS, 32'h0, 4'hf);
    endtask

    task automatic t_err();
        apb(1'b0, 12'h00c, 32'h0, 4'hf);
        `CHK({er, rd}, {1'b1, 32'h0}, "unmapped read")
        apb(1'b1, vpg_pkg::VPG_STAT_OFS, 32'hffffffff, 4'hf);
        `CHK(er, 1'b1, "status write")
        apb(1'b0, vpg_pkg::VPG_STAT_OFS, 32'h0, 4'hf);
        `CHK({er, rd[10:0] inside {[11'd1:11'd525]}}, 2'b01, "status line")
        apb(1'b0, vpg_pkg::VPG_FRAME_OFS, 32'h0, 4'hf);
        `CHK(rd, 32'h0, "frame count")
    endtask

    task automatic t_bars();
        int n;
        n = 0;
        while (!(vid.trs === 1'b1 && vid.line === 11'd25) && n < 30000) begin
            @(negedge pclk);
            n++;
        end
        repeat (134) @(negedge pclk);
        `CHK({vid.trs, vid.line}, {1'b1, 11'd25}, "sav of line 25")
        repeat (4) @(negedge pclk);
        for (int k = 0; k < 720; k++) begin
            if (k % 90 == 44) `CHK({vid.y, vid.c}, {y75[k / 90], cb75[k / 90]}, "bar luma or cb")
            if (k % 90 == 45) `CHK(vid.c, cr75[k / 90], "bar cr")
            @(negedge pclk);
        end
        `CHK(frac, 1'b0, "integer rate")
    endtask

    task results();
        if (error_cnt == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Clock of 25 ns.
    initial begin
        forever #12.5 pclk = ~pclk;
    end

    // The first frame needs about 20600 cycles to reach line 25, so 40000 is ample.
    initial begin
        repeat (40000) @(posedge pclk);
        error_cnt++;
        results();
    end

    // Main sequence.
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_walk();
        t_regs();
        t_err();
        t_bars();
        `CHK({sink_bad == 32'h0, sink_trs > 32'h0}, 2'b11, "sink line order")
        results();
    end
endmodule
